// *** shared/bfec_pkg.sv ***
package bfec_pkg;

  // ---------------------------------------------------------------------
  // Register selectors on the processor register port
  // ---------------------------------------------------------------------
  localparam logic [1:0] BFEC_SEL_STATUS = 2'h0;
  localparam logic [1:0] BFEC_SEL_BUS_ADDR = 2'h1;
  localparam logic [1:0] BFEC_SEL_FILL_ADDR = 2'h2;
  localparam logic [1:0] BFEC_SEL_DCACHE = 2'h3;

  // ---------------------------------------------------------------------
  // Status register field positions
  // ---------------------------------------------------------------------
  localparam int BFEC_STAT_W = 15;
  localparam int BFEC_HERR_POS = 0;
  localparam int BFEC_SERR_POS = 1;
  localparam int BFEC_TPERR_POS = 2;
  localparam int BFEC_TCPERR_POS = 3;
  localparam int BFEC_CMD_LSB = 4;
  localparam int BFEC_FIRST_FATAL_FLAG_POS = 7;
  localparam int BFEC_FEDC_POS = 8;
  localparam int BFEC_FDPERR_POS = 9;
  localparam int BFEC_FIRD_POS = 10;
  localparam int BFEC_FQW_LSB = 11;
  localparam int BFEC_SECOND_FATAL_FLAG_POS = 14;

  // ---------------------------------------------------------------------
  // Address layout
  // ---------------------------------------------------------------------
  localparam int BFEC_ADR_HI = 33;
  localparam int BFEC_BLK_LSB = 5;
  localparam int BFEC_ADR_LO = 2;
  localparam logic [63:0] BFEC_ADDR_RESET = 64'h0000_0000_0000_0000;

  // ---------------------------------------------------------------------
  // Pin encodings
  // ---------------------------------------------------------------------
  localparam logic [2:0] BFEC_ACK_HARD_FAULT = 3'h3;
  localparam logic [2:0] BFEC_ACK_SOFT_ERROR = 3'h2;
  localparam logic [2:0] BFEC_CMD_READ_BLOCK = 3'h4;
  localparam logic [2:0] BFEC_CMD_LOAD_LOCKED = 3'h5;
  localparam int BFEC_PIN_W = 1 + 3 + 3 + 32;

  typedef struct packed {
    logic ack_valid;
    logic [2:0] cycle_acknowledge_pins;
    logic [2:0] cycle_request_pins;
    logic [33:2] adr;
  } bfec_pins_t;

  typedef struct packed {
    logic valid;
    logic ecc_error;
    logic uncorrectable;
    logic parity_error;
    logic icache;
    logic [1:0] quadword;
    logic [33:2] adr;
  } bfec_fill_t;

  typedef struct packed {
    logic valid;
    logic tag_parity;
    logic tag_control_parity;
  } bfec_tag_t;

  typedef struct packed {
    logic ack_hard_fault_flag;
    logic soft_error_flag;
    logic tag_parity_flag;
    logic tag_control_parity_flag;
    logic [2:0] bus_command_field;
    logic first_fatal_flag;
    logic fill_ecc_error_flag;
    logic fill_data_parity_flag;
    logic instruction_fill_indicator;
    logic [1:0] fill_quadword_field;
    logic second_fatal_flag;
    logic bus_lock;
    logic fill_lock;
    logic [63:0] bus_error_address;
    logic [63:0] fill_error_address;
    logic [63:0] rd_data;
    logic rd_valid;
    logic dcache_unlock;
    logic fill_syndrome_unlock;
  } bfec_state_t;

endpackage

// *** src/bfec_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module bfec_sync
  import bfec_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // Only the second stage is visible, so a metastable first stage never reaches logic.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= '0;
      q <= '0;
    end else if (ce) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// *** src/bfec_capture.sv ***
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - A bus or tag error freezes status bits 6..0 and captures the bus address.
// - Fill parity or uncorrectable ECC errors also freeze bus status and address.
// - Reading the bus error address unlocks it and status bits 7..0.
// - A fill ECC or parity error freezes bits 12..8 and captures fill address.
// - Reading fill address unlocks it, status bits 14..8 and the fill syndrome.
// - Reset neither clears nor unlocks status; firmware clears it by writing.
// - Hard fault acknowledge on a bus cycle sets the ack_hard_fault flag.
// - Soft error acknowledge on a bus cycle sets the soft error flag.
// - Bad tag or tag control parity on a probe sets its parity flag.
// - Any bus or tag error captures the cycle request code into the command field.
// - Hard fault or tag error while a bus or tag flag is set sets first fatal.
// - In ECC mode only, fill data with an ECC error sets the fill ECC error flag.
// - In parity mode only, bad fill data parity sets the fill parity flag.
// - A recorded fill error notes whether the fill was for the instruction cache.
// - A recorded fill error stores which quadword of the block was bad.
// - Uncorrectable or parity fill error while a fill flag is set sets second fatal.
// - Bus address holds pin bits 33..5; bits 63..34 and 1..0 read zero.
// - Bus address bits 4..2 are zero unless the command was block read or load-locked.
// - Fill address bits 33..5 give the 32-byte block being filled.
// - Data fills keep load address bits 4..2; upper and lowest bits read zero.
// - Reading the data cache address location only unlocks the data cache status.

module bfec_capture
  import bfec_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic ack_valid,
  input wire logic [2:0] cycle_acknowledge_pins,
  input wire logic [2:0] cycle_request_pins,
  input wire logic [33:2] adr,
  input wire bfec_tag_t tag_in,
  input wire bfec_fill_t fill_in,
  input wire logic ecc_mode,
  input wire logic ipr_rd,
  input wire logic ipr_wr,
  input wire logic [1:0] ipr_sel,
  output logic [63:0] rd_data,
  output logic rd_valid,
  output logic dcache_unlock,
  output logic fill_syndrome_unlock,
  output logic bus_locked,
  output logic fill_locked
);

  // ---------------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------------
  bfec_pins_t pins_raw;
  bfec_pins_t pins;
  logic [BFEC_PIN_W-1:0] pins_q;

  assign pins_raw = '{ack_valid: ack_valid, cycle_acknowledge_pins: cycle_acknowledge_pins,
                      cycle_request_pins: cycle_request_pins, adr: adr};
  assign pins = bfec_pins_t'(pins_q);

  // The pins are sampled as one word; the system holds them steady while the
  // acknowledge is valid, so the word never tears across the two stages.
  bfec_sync #(
    .W(BFEC_PIN_W)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .d(pins_raw),
    .q(pins_q)
  );

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  function automatic logic [63:0] bfec_addr(input logic [33:2] a, input logic keep_low);
    logic [63:0] r;
    r = BFEC_ADDR_RESET;
    r[BFEC_ADR_HI:BFEC_BLK_LSB] = a[BFEC_ADR_HI:BFEC_BLK_LSB];
    if (keep_low) begin
      r[BFEC_BLK_LSB-1:BFEC_ADR_LO] = a[BFEC_BLK_LSB-1:BFEC_ADR_LO];
    end
    return r;
  endfunction

  function automatic logic [BFEC_STAT_W-1:0] bfec_status(input bfec_state_t s);
    logic [BFEC_STAT_W-1:0] r;
    r = '0;
    r[BFEC_HERR_POS] = s.ack_hard_fault_flag;
    r[BFEC_SERR_POS] = s.soft_error_flag;
    r[BFEC_TPERR_POS] = s.tag_parity_flag;
    r[BFEC_TCPERR_POS] = s.tag_control_parity_flag;
    r[BFEC_CMD_LSB +: 3] = s.bus_command_field;
    r[BFEC_FIRST_FATAL_FLAG_POS] = s.first_fatal_flag;
    r[BFEC_FEDC_POS] = s.fill_ecc_error_flag;
    r[BFEC_FDPERR_POS] = s.fill_data_parity_flag;
    r[BFEC_FIRD_POS] = s.instruction_fill_indicator;
    r[BFEC_FQW_LSB +: 2] = s.fill_quadword_field;
    r[BFEC_SECOND_FATAL_FLAG_POS] = s.second_fatal_flag;
    return r;
  endfunction

  // ---------------------------------------------------------------------
  // Event decode
  // ---------------------------------------------------------------------
  logic ev_hard;
  logic ev_soft;
  logic ev_tp;
  logic ev_tcp;
  logic ev_bus;
  logic ev_fill_ecc_error_flag;
  logic ev_fill_par;
  logic ev_fill;
  logic ev_fill_bad;
  logic any_bus_flag;
  logic any_fill_flag;
  logic rd_bus_addr;
  logic rd_fill_addr;
  logic wr_status;
  logic long_cmd;

  always_comb begin
    ev_hard = pins.ack_valid && (pins.cycle_acknowledge_pins == BFEC_ACK_HARD_FAULT);
    ev_soft = pins.ack_valid && (pins.cycle_acknowledge_pins == BFEC_ACK_SOFT_ERROR);
    ev_tp = tag_in.valid && tag_in.tag_parity;
    ev_tcp = tag_in.valid && tag_in.tag_control_parity;
    ev_bus = ev_hard || ev_soft || ev_tp || ev_tcp;
    ev_fill_ecc_error_flag = fill_in.valid && ecc_mode && fill_in.ecc_error;
    ev_fill_par = fill_in.valid && !ecc_mode && fill_in.parity_error;
    ev_fill = ev_fill_ecc_error_flag || ev_fill_par;
    ev_fill_bad = (fill_in.valid && ecc_mode && fill_in.uncorrectable) || ev_fill_par;
    rd_bus_addr = ipr_rd && (ipr_sel == BFEC_SEL_BUS_ADDR);
    rd_fill_addr = ipr_rd && (ipr_sel == BFEC_SEL_FILL_ADDR);
    wr_status = ipr_wr && (ipr_sel == BFEC_SEL_STATUS);
    long_cmd = (pins.cycle_request_pins == BFEC_CMD_READ_BLOCK) ||
               (pins.cycle_request_pins == BFEC_CMD_LOAD_LOCKED);
  end

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  bfec_state_t st_reg;
  bfec_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.rd_valid = 1'b0;
    st_next.dcache_unlock = 1'b0;
    st_next.fill_syndrome_unlock = 1'b0;
    any_bus_flag = st_reg.ack_hard_fault_flag || st_reg.soft_error_flag ||
                   st_reg.tag_parity_flag || st_reg.tag_control_parity_flag;
    any_fill_flag = st_reg.fill_ecc_error_flag || st_reg.fill_data_parity_flag;

    // Reads return the value held before this cycle's unlock or capture.
    if (ipr_rd) begin
      st_next.rd_valid = 1'b1;
      unique case (ipr_sel)
        BFEC_SEL_STATUS: st_next.rd_data = 64'(bfec_status(st_reg));
        BFEC_SEL_BUS_ADDR: st_next.rd_data = st_reg.bus_error_address;
        BFEC_SEL_FILL_ADDR: st_next.rd_data = st_reg.fill_error_address;
        BFEC_SEL_DCACHE: st_next.rd_data = BFEC_ADDR_RESET;
      endcase
    end
    if (rd_bus_addr) begin
      st_next.bus_lock = 1'b0;
    end
    if (rd_fill_addr) begin
      st_next.fill_lock = 1'b0;
      st_next.fill_syndrome_unlock = 1'b1;
    end
    if (ipr_rd && (ipr_sel == BFEC_SEL_DCACHE)) begin
      st_next.dcache_unlock = 1'b1;
    end

    // Firmware clears status explicitly; errors in the same cycle still land.
    if (wr_status) begin
      st_next.ack_hard_fault_flag = 1'b0;
      st_next.soft_error_flag = 1'b0;
      st_next.tag_parity_flag = 1'b0;
      st_next.tag_control_parity_flag = 1'b0;
      st_next.bus_command_field = 3'h0;
      st_next.first_fatal_flag = 1'b0;
      st_next.fill_ecc_error_flag = 1'b0;
      st_next.fill_data_parity_flag = 1'b0;
      st_next.instruction_fill_indicator = 1'b0;
      st_next.fill_quadword_field = 2'h0;
      st_next.second_fatal_flag = 1'b0;
      st_next.bus_lock = 1'b0;
      st_next.fill_lock = 1'b0;
    end

    // Fatal flags look at the flags as held, before any clear this cycle.
    if ((ev_hard || ev_tp || ev_tcp) && any_bus_flag) begin
      st_next.first_fatal_flag = 1'b1;
    end
    if (ev_fill_bad && any_fill_flag) begin
      st_next.second_fatal_flag = 1'b1;
    end

    // A lock released by this cycle's read or clear lets a new error in.
    if (ev_bus && !st_next.bus_lock) begin
      st_next.ack_hard_fault_flag = st_next.ack_hard_fault_flag || ev_hard;
      st_next.soft_error_flag = st_next.soft_error_flag || ev_soft;
      st_next.tag_parity_flag = st_next.tag_parity_flag || ev_tp;
      st_next.tag_control_parity_flag = st_next.tag_control_parity_flag || ev_tcp;
      st_next.bus_command_field = pins.cycle_request_pins;
      st_next.bus_error_address = bfec_addr(pins.adr, long_cmd);
      st_next.bus_lock = 1'b1;
    end else if (ev_fill_bad && !st_next.bus_lock) begin
      // Bad fills freeze the bus group too, without recording a bus flag.
      st_next.bus_error_address = bfec_addr(fill_in.adr, 1'b0);
      st_next.bus_lock = 1'b1;
    end

    if (ev_fill && !st_next.fill_lock) begin
      st_next.fill_ecc_error_flag = st_next.fill_ecc_error_flag || ev_fill_ecc_error_flag;
      st_next.fill_data_parity_flag = st_next.fill_data_parity_flag || ev_fill_par;
      st_next.instruction_fill_indicator = fill_in.icache;
      st_next.fill_quadword_field = fill_in.quadword;
      st_next.fill_error_address = bfec_addr(fill_in.adr, !fill_in.icache);
      st_next.fill_lock = 1'b1;
    end
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------
  // Only the read port and the unlock pulses are reset; the error record and its locks survive a
  // reset so that firmware can still inspect what caused it.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg.rd_data <= BFEC_ADDR_RESET;
      st_reg.rd_valid <= 1'b0;
      st_reg.dcache_unlock <= 1'b0;
      st_reg.fill_syndrome_unlock <= 1'b0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign rd_data = st_reg.rd_data;
  assign rd_valid = st_reg.rd_valid;
  assign dcache_unlock = st_reg.dcache_unlock;
  assign fill_syndrome_unlock = st_reg.fill_syndrome_unlock;
  assign bus_locked = st_reg.bus_lock;
  assign fill_locked = st_reg.fill_lock;

endmodule

`default_nettype wire

// *** test/bfec_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module bfec_props
  import bfec_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic ack_valid,
  input wire logic [2:0] cycle_acknowledge_pins,
  input wire bfec_tag_t tag_in,
  input wire bfec_fill_t fill_in,
  input wire logic ecc_mode,
  input wire logic ipr_rd,
  input wire logic ipr_wr,
  input wire logic [1:0] ipr_sel,
  input wire logic dcache_unlock,
  input wire logic fill_syndrome_unlock,
  input wire logic bus_locked,
  input wire logic fill_locked
);
  // ---------------------------------------------------------------------
  // Lock and unlock checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // An ack still in the pin synchroniser could relock right after an unlock.
  sequence s_no_ack;
    !ack_valid && !$past(ack_valid) && !$past(ack_valid, 2);
  endsequence
  sequence s_rd(logic [1:0] s);
    ce && ipr_rd && ipr_sel == s;
  endsequence
  chk_bus_unlock: assert property (s_rd(2'h1) ##0 s_no_ack ##0 !tag_in.valid && !fill_in.valid |=> !bus_locked)
    else $error("bus group still locked after address read");
  chk_fill_unlock: assert property (s_rd(2'h2) ##0 !fill_in.valid |=> !fill_locked && fill_syndrome_unlock)
    else $error("fill group still locked after address read");
  chk_dcache_pulse: assert property (1 |=> dcache_unlock == $past(ce && ipr_rd && ipr_sel == 2'h3))
    else $error("data cache unlock pulse wrong");
  chk_tag_lock: assert property (ce && tag_in.valid && (tag_in.tag_parity || tag_in.tag_control_parity)
    |=> bus_locked)
    else $error("tag error did not lock bus group");
  chk_ack_lock: assert property (ce && ack_valid && cycle_acknowledge_pins inside {3'h2, 3'h3}
    |-> ##[2:3] bus_locked)
    else $error("error ack did not lock bus group");
  chk_fill_lock: assert property (ce && fill_in.valid && (ecc_mode ? fill_in.ecc_error : fill_in.parity_error)
    |=> fill_locked)
    else $error("fill error did not lock fill group");
  chk_fill_bus: assert property (ce && fill_in.valid && (ecc_mode ? fill_in.uncorrectable : fill_in.parity_error)
    |=> bus_locked)
    else $error("bad fill did not lock bus group");
  chk_bus_hold: assert property (bus_locked && !(ce && (ipr_rd && ipr_sel == 2'h1 || ipr_wr && ipr_sel == 2'h0))
    |=> bus_locked)
    else $error("bus group lock dropped");
  chk_fill_hold: assert property (fill_locked && !(ce && (ipr_rd && ipr_sel == 2'h2 || ipr_wr && ipr_sel == 2'h0))
    |=> fill_locked)
    else $error("fill group lock dropped");
endmodule
`default_nettype wire

// *** test/bfec_bus_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module bfec_bus_model
  import bfec_pkg::*;
(
  input wire logic ref_clk,
  output var bfec_pins_t pins,
  output var bfec_fill_t fill
);
  // ---------------------------------------------------------------------
  // System side: ends bus cycles and returns fill beats
  // ---------------------------------------------------------------------
  initial begin
    pins = '0;
    fill = '0;
  end
  // Released pins show the inverse so stale values are never mistaken for data.
  task automatic cycle(input logic [2:0] ack, input logic [2:0] cmd, input logic [31:0] a);
    @(posedge ref_clk);
    #1 pins = '{1'h1, ack, cmd, a};
    @(posedge ref_clk);
    #1 pins = '{1'h0, ~ack, ~cmd, ~a};
  endtask
  task automatic beat(input bfec_fill_t f);
    @(posedge ref_clk);
    #1 fill = f;
    @(posedge ref_clk);
    #1 fill = ~f;
  endtask
endmodule
`default_nettype wire

// *** test/tb_bus_fill_error_capture.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_bus_fill_error_capture;
  import bfec_pkg::*;
  logic ref_clk, rstn, ce, ecc_mode, ipr_rd, ipr_wr;
  logic [1:0] ipr_sel;
  bfec_tag_t tag_in;
  bfec_pins_t pins;
  bfec_fill_t fill;
  logic [63:0] rd_data, got;
  logic rd_valid, dcache_unlock, fill_syndrome_unlock, bus_locked, fill_locked;
  int n_errors, compares, cycles;
  localparam logic [31:0] A = 32'hC8D1_59E7;
  localparam logic [31:0] F = 32'h5A3C_0F6B;
  localparam logic [14:0] NOCMD = 15'h7F8F;
  localparam logic [14:0] ALL = 15'h7FFF;
  // ---------------------------------------------------------------------
  // Harness
  // ---------------------------------------------------------------------
  bfec_capture i_bfec_capture (.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .ack_valid(pins.ack_valid),
    .cycle_acknowledge_pins(pins.cycle_acknowledge_pins), .cycle_request_pins(pins.cycle_request_pins),
    .adr(pins.adr), .tag_in(tag_in), .fill_in(fill), .ecc_mode(ecc_mode), .ipr_rd(ipr_rd), .ipr_wr(ipr_wr),
    .ipr_sel(ipr_sel), .rd_data(rd_data), .rd_valid(rd_valid), .dcache_unlock(dcache_unlock),
    .fill_syndrome_unlock(fill_syndrome_unlock), .bus_locked(bus_locked), .fill_locked(fill_locked));
  bfec_bus_model i_bfec_bus_model (.ref_clk(ref_clk), .pins(pins), .fill(fill));
  initial begin
    ref_clk = 1'h0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [63:0] g, input logic [63:0] e, input string m);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  function automatic logic [63:0] ea(input logic [31:0] a, input logic keep);
    return {30'h0, a[31:3], keep ? a[2:0] : 3'h0, 2'h0};
  endfunction
  task automatic rd(input logic [1:0] s);
    @(posedge ref_clk);
    #1 ipr_rd = 1'h1;
    ipr_sel = s;
    @(posedge ref_clk);
    #1 ipr_rd = 1'h0;
    check({63'h0, rd_valid}, 64'h1, "read answer");
    got = rd_data;
  endtask
  task automatic clr();
    @(posedge ref_clk);
    #1 ipr_wr = 1'h1;
    ipr_sel = BFEC_SEL_STATUS;
    @(posedge ref_clk);
    #1 ipr_wr = 1'h0;
  endtask
  task automatic stat(input logic [14:0] e, input logic [14:0] m);
    rd(BFEC_SEL_STATUS);
    check(got & {49'h0, m}, {49'h0, e}, "status");
  endtask
  task automatic tag(input logic tp, input logic tc);
    @(posedge ref_clk);
    #1 tag_in = '{1'h1, tp, tc};
    @(posedge ref_clk);
    #1 tag_in = '{1'h0, ~tp, ~tc};
  endtask
  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_bus();
    clr();
    stat(15'h0000, ALL);
    i_bfec_bus_model.cycle(BFEC_ACK_HARD_FAULT, BFEC_CMD_READ_BLOCK, A);
    repeat (4) @(posedge ref_clk);
    stat(15'h0041, ALL);
    rd(BFEC_SEL_BUS_ADDR);
    check(got, ea(A, 1'h1), "bus address");
    check({63'h0, bus_locked}, 64'h0, "bus unlock");
    i_bfec_bus_model.cycle(BFEC_ACK_SOFT_ERROR, 3'h1, ~A);
    repeat (4) @(posedge ref_clk);
    stat(15'h0013, ALL);
    i_bfec_bus_model.cycle(BFEC_ACK_HARD_FAULT, 3'h6, A);
    repeat (4) @(posedge ref_clk);
    stat(15'h0093, ALL);
    rd(BFEC_SEL_BUS_ADDR);
    check(got, ea(~A, 1'h0), "frozen bus address");
    $display("test bus done");
  endtask
  task automatic t_tag();
    clr();
    tag(1'h0, 1'h1);
    stat(15'h0008, NOCMD);
    rd(BFEC_SEL_BUS_ADDR);
    tag(1'h1, 1'h0);
    stat(15'h008C, NOCMD);
    $display("test tag done");
  endtask
  task automatic t_fill();
    ecc_mode = 1'h1;
    clr();
    i_bfec_bus_model.beat('{1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 2'h2, F});
    stat(15'h1100, NOCMD);
    check({63'h0, bus_locked}, 64'h1, "fill locks bus group");
    i_bfec_bus_model.beat('{1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 2'h0, A});
    stat(15'h5100, NOCMD);
    rd(BFEC_SEL_FILL_ADDR);
    check(got, ea(F, 1'h1), "fill address");
    check({63'h0, fill_locked}, 64'h0, "fill unlock");
    rd(BFEC_SEL_BUS_ADDR);
    check(got, ea(F, 1'h0), "bus address from fill");
    ecc_mode = 1'h0;
    clr();
    i_bfec_bus_model.beat('{1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 2'h1, F});
    stat(15'h0E00, NOCMD);
    rd(BFEC_SEL_FILL_ADDR);
    check(got, ea(F, 1'h0), "instruction fill address");
    $display("test fill done");
  endtask
  task automatic t_misc();
    rd(BFEC_SEL_DCACHE);
    check({63'h0, dcache_unlock}, 64'h1, "dcache unlock");
    clr();
    tag(1'h1, 1'h0);
    rstn = 1'h0;
    repeat (3) @(posedge ref_clk);
    #1 rstn = 1'h1;
    stat(15'h0004, NOCMD);
    check({63'h0, bus_locked}, 64'h1, "lock kept over reset");
    clr();
    ce = 1'h0;
    tag(1'h1, 1'h1);
    ce = 1'h1;
    stat(15'h0000, NOCMD);
    $display("test misc done");
  endtask
  initial begin
    rstn = 1'h0;
    ce = 1'h1;
    ecc_mode = 1'h0;
    ipr_rd = 1'h0;
    ipr_wr = 1'h0;
    ipr_sel = 2'h0;
    tag_in = '0;
    n_errors = 0;
    compares = 0;
    cycles = 0;
    repeat (20) @(posedge ref_clk);
    #1 rstn = 1'h1;
    t_bus();
    t_tag();
    t_fill();
    t_misc();
    test_done();
  end
endmodule
bind bfec_capture bfec_props i_bfec_props (.*);
`default_nettype wire
